// [design/quad_hdlc_channel_access.sv]
// Purpose: four hdlc framers on a time-division serial highway
// Assumes: serial bit clock well below the core clock (4 core cycles per edge or more)
// Notes: all state sits in one struct; pins pass three flip-flops
`include "quad_hdlc_map.svh"
// Overview of operation
// - receive bits sampled at bit clock fall, transmit bits launched at rise
// - double-rate input selects one or two bit clock periods per bit
// - data lane enable is off outside the owning controller's slot
// - slot start is the 8-bit position times two bits from frame sync
// - slot length 1, 2, 7 or 8 bits, shared by receive and transmit
// - bit counter wraps itself at 256 or 512 bits per frame
// - quad modes use lanes 0 to 3, single modes share lane 0
// - quad time-slot mode: marker low only in controller B's slot
// - common-control mode: frame sync high is the slot for all, marker follows
// - single time-slot mode: marker low during any controller's slot
// - subscriber bus: D bit pairs of bus channels 0-3 or 4-7
// - marker push-pull; lanes push-pull or open-drain, bus mode open-drain
// - zero, six ones, zero is a flag
// - transmit stuffs a zero after five ones, receive deletes it
// - 16-bit crc x16+x12+x5+1 made on transmit, checked on receive
// - seven or more ones abort a received frame
// - fifteen or more ones drive the line idle status bit
// - frames under three bytes between flags vanish silently
// - flags around frames, flag or ones fill, abort on command or underrun
// - 64-byte fifo per direction handed over in 32-byte blocks, no crc
// - first byte compared with sapi 63, 0, 16; none enabled accepts all
// - mode code 00 single slot, 01 common, 10 bus, 11 quad slot
module quad_hdlc_channel_access (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic SERIAL_BIT_CLOCK_I,
   input wire logic FRAME_SYNC_STROBE_I,
   input wire logic [3:0] SERIAL_RX_LANE_I,
   input wire logic LINK_MODE_HI_I,
   input wire logic LINK_MODE_LO_I,
   input wire logic DOUBLE_RATE_I,
   input wire logic OPEN_DRAIN_I,
   input wire logic FRAME_512_I,
   input wire logic BUS_CHANNEL_GROUP_SEL_I,
   input wire quad_hdlc_pkg::chan_cfg_s [3:0] CHAN_CFG_I,
   input wire quad_hdlc_pkg::tx_host_s [3:0] TX_HOST_I,
   input wire logic [3:0] RX_READ_I,
   output logic [3:0] SERIAL_TX_LANE_O,
   output logic [3:0] SERIAL_TX_LANE_OE_O,
   output logic SLOT_MARKER_OUT_N_O,
   output logic [3:0] TX_READY_O,
   output quad_hdlc_pkg::rx_word_s [3:0] RX_WORD_O,
   output logic [3:0] LINE_IDLE_O
);
   import quad_hdlc_pkg::*;

   state_s r;
   state_s n;

   function automatic logic [15:0] crc_step(logic [15:0] c, logic d);
      crc_step = (c >> 1) ^ ((c[0] ^ d) ? `CRC_POLY : 16'h0000);
   endfunction

   function automatic logic slot_hit(logic [1:0] i, logic [8:0] bc,
         chan_cfg_s cf, link_mode_e m, logic grp, logic fs);
      logic [8:0] len;
      logic [8:0] d;
      case (cf.slot_len)
         2'h0: len = `LEN_1;
         2'h1: len = `LEN_2;
         2'h2: len = `LEN_7;
         default: len = `LEN_8;
      endcase
      d = bc - {cf.slot_pos, 1'b0};
      case (m)
         M_QUAD_CC: slot_hit = fs;
         M_SUB_BUS: slot_hit = bc[8:1] == {1'b0, grp, i, `BUS_D_PAIR};
         default: slot_hit = d < len;
      endcase
   endfunction

   function automatic chan_s rx_push(chan_s c, logic st, logic [7:0] d);
      logic [6:0] cnt;
      rx_push = c;
      cnt = c.rwr - c.rrd;
      if (cnt < (st ? `FIFO_DEPTH : `DATA_LIM)) begin
         rx_push.rxm[c.rwr[5:0]] = {st, d};
         rx_push.rwr = c.rwr + 7'h01;
         rx_push.rblk = c.rblk + 6'h01;
         // hand a block over when full or at frame end
         if (st || rx_push.rblk == `BLK_SIZE) begin
            rx_push.rcm = rx_push.rwr;
            rx_push.rblk = 6'h00;
         end
      end else begin
         rx_push.ovf = 1'b1;
      end
   endfunction

   always_comb begin
      chan_s c;
      link_mode_e m;
      logic rise;
      logic fall;
      logic brise;
      logic bfall;
      logic fsn;
      logic b;
      logic d;
      logic od;
      logic quad;
      logic stuffing;
      logic [1:0] ln;
      logic [3:0] hv;
      logic [7:0] by;
      logic [7:0] stb;
      c = '0;
      m = link_mode_e'({LINK_MODE_HI_I, LINK_MODE_LO_I});
      b = 1'b0;
      d = 1'b0;
      stuffing = 1'b0;
      ln = 2'h0;
      hv = 4'h0;
      by = 8'h00;
      stb = 8'h00;
      n = r;
      n.s0 = {FRAME_SYNC_STROBE_I, SERIAL_BIT_CLOCK_I, SERIAL_RX_LANE_I};
      n.s1 = r.s0;
      n.s2 = r.s1;
      for (int k = 0; k < 6; k++) begin
         if (r.s1[k] == r.s2[k]) begin
            n.lv[k] = r.s2[k];
         end
      end
      rise = n.lv[`PIN_CLK] & ~r.lv[`PIN_CLK];
      fall = ~n.lv[`PIN_CLK] & r.lv[`PIN_CLK];
      fsn = r.lv[`PIN_FS] & ~r.fsp;
      // a new frame sync also realigns the double-rate phase
      brise = rise & (~DOUBLE_RATE_I | ~r.ph | fsn);
      bfall = fall & (~DOUBLE_RATE_I | ~r.ph);
      quad = m[0];
      od = OPEN_DRAIN_I | (m == M_SUB_BUS);
      if (rise) begin
         n.ph = brise ? 1'b1 : ~r.ph;
         n.fsp = r.lv[`PIN_FS];
      end
      if (brise) begin
         if (fsn) begin
            n.bc = 9'h000;
         end else if (r.bc == (FRAME_512_I ? `WRAP_512 : `WRAP_256)) begin
            n.bc = 9'h000;
         end else begin
            n.bc = r.bc + 9'h001;
         end
         n.loe = 4'h0;
         n.lo = 4'h0;
      end
      for (int i = 0; i < 4; i++) begin
         c = r.ch[i];
         ln = quad ? 2'(i) : 2'h0;
         // host side of the transmit fifo
         if (TX_HOST_I[i].abort) begin
            c.tabt = 1'b1;
         end
         if (TX_HOST_I[i].wr && r.ch[i].trdy) begin
            c.txm[c.twr[5:0]] = {TX_HOST_I[i].last, TX_HOST_I[i].data};
            c.twr = c.twr + 7'h01;
            c.tblk = c.tblk + 6'h01;
            if (TX_HOST_I[i].last || c.tblk == `BLK_SIZE) begin
               c.tcm = c.twr;
               c.tblk = 6'h00;
            end
         end
         if (RX_READ_I[i] && r.ch[i].rxo.valid) begin
            c.rrd = c.rrd + 7'h01;
         end
         if (brise) begin
            hv[i] = slot_hit(2'(i), n.bc, CHAN_CFG_I[i], m,
               BUS_CHANNEL_GROUP_SEL_I, r.lv[`PIN_FS]);
            c.act = hv[i];
         end
         // transmit one bit per slot bit at the rising edge
         if (brise && hv[i]) begin
            stuffing = c.st == T_DATA || c.st == T_CRC1 || c.st == T_CRC2;
            // five ones at the end of the crc still need their zero before the flag
            if ((stuffing || c.st == T_CLOSE) && c.tones == `STUFF_ONES) begin
               d = 1'b0;
               c.tones = 4'h0;
            end else begin
               d = c.tsh[0];
               c.tsh = {1'b1, c.tsh[7:1]};
               if (c.st == T_DATA) begin
                  c.tcrc = crc_step(c.tcrc, d);
               end
               c.tones = (stuffing && d) ? c.tones + 4'h1 : 4'h0;
               c.tn = c.tn + 3'h1;
               if (c.tn == 3'h0) begin
                  case (c.st)
                     T_OPEN, T_DATA: begin
                        if (c.st == T_DATA && c.tlast) begin
                           c.tsh = ~c.tcrc[7:0];
                           c.st = T_CRC1;
                        end else if (c.tabt || c.trd == c.tcm) begin
                           c.tsh = `ONES_BYTE;
                           c.st = T_ABORT;
                        end else begin
                           if (c.st == T_OPEN) begin
                              c.tcrc = `CRC_INIT;
                           end
                           {c.tlast, c.tsh} = c.txm[c.trd[5:0]];
                           c.trd = c.trd + 7'h01;
                           c.st = T_DATA;
                        end
                     end
                     T_CRC1: begin
                        c.tsh = ~c.tcrc[15:8];
                        c.st = T_CRC2;
                     end
                     T_CRC2: begin
                        c.tsh = `FLAG_BYTE;
                        c.st = T_CLOSE;
                     end
                     T_IDLE: begin
                        if (!c.tabt && c.trd != c.tcm) begin
                           c.tsh = `FLAG_BYTE;
                           c.st = T_OPEN;
                        end else begin
                           c.tsh = CHAN_CFG_I[i].ones_fill ? `ONES_BYTE : `FLAG_BYTE;
                        end
                     end
                     default: begin
                        c.tsh = CHAN_CFG_I[i].ones_fill ? `ONES_BYTE : `FLAG_BYTE;
                        c.st = T_IDLE;
                     end
                  endcase
               end
            end
            // drive the lane; open-drain only pulls low
            n.lo[ln] = od ? 1'b0 : d;
            n.loe[ln] = od ? ~d : 1'b1;
         end
         // an abort command drops the frame in flight and the queued data
         if (c.tabt && (c.st == T_ABORT || c.st == T_IDLE)) begin
            c.tabt = 1'b0;
            c.trd = c.twr;
            c.tcm = c.twr;
            c.tblk = 6'h00;
         end
         // receive one bit per slot bit at the falling edge
         if (bfall && r.ch[i].act) begin
            b = r.lv[ln];
            if (b) begin
               if (c.ones != `IDLE_ONES) begin
                  c.ones = c.ones + 4'h1;
               end
               if (c.ones == `ABORT_ONES) begin
                  if (c.infr && c.nby >= `MIN_BYTES && !c.rej) begin
                     stb = 8'h00;
                     stb[`ST_ABORT] = 1'b1;
                     stb[`ST_OVF] = c.ovf;
                     c = rx_push(c, 1'b1, stb);
                  end
                  c.infr = 1'b0;
               end
            end else if (c.ones == `FLAG_ONES) begin
               if (c.infr && c.nb == 3'h0 && c.nby >= `MIN_BYTES && !c.rej) begin
                  stb = 8'h00;
                  stb[`ST_CRC_OK] = c.crc == `CRC_GOOD;
                  stb[`ST_OVF] = c.ovf;
                  c = rx_push(c, 1'b1, stb);
               end
               c.infr = 1'b1;
               c.dn = 3'h0;
               c.nb = 3'h0;
               c.nby = 6'h00;
               c.hn = 2'h0;
               c.crc = `CRC_INIT;
               c.rej = 1'b0;
               c.ovf = 1'b0;
            end
            // the last seven bits wait, so flag bits never reach the data
            if (b || (c.ones != `FLAG_ONES && c.ones != `STUFF_ONES)) begin
               if (c.dn == `DLY_FULL && c.infr) begin
                  c.crc = crc_step(c.crc, c.dly[0]);
                  by = {c.dly[0], c.sh[7:1]};
                  c.sh = by;
                  c.nb = c.nb + 3'h1;
                  if (c.nb == 3'h0) begin
                     if (c.nby == 6'h00 && |CHAN_CFG_I[i].addr_cmp) begin
                        c.rej = !((CHAN_CFG_I[i].addr_cmp[`CMP_GROUP]
                                     && by[7:2] == `SAPI_GROUP)
                                  || (CHAN_CFG_I[i].addr_cmp[`CMP_SIG]
                                     && by[7:2] == `SAPI_SIG)
                                  || (CHAN_CFG_I[i].addr_cmp[`CMP_PKT]
                                     && by[7:2] == `SAPI_PKT));
                     end
                     if (c.nby != `BYTE_CAP) begin
                        c.nby = c.nby + 6'h01;
                     end
                     // two bytes held back so the crc never enters the fifo
                     if (c.hn == `HOLD_FULL && !c.rej) begin
                        c = rx_push(c, 1'b0, c.h1);
                     end
                     c.h1 = c.h0;
                     c.h0 = by;
                     if (c.hn != `HOLD_FULL) begin
                        c.hn = c.hn + 2'h1;
                     end
                  end
               end
               c.dly = {b, c.dly[6:1]};
               if (c.dn != `DLY_FULL) begin
                  c.dn = c.dn + 3'h1;
               end
            end
            if (!b) begin
               c.ones = 4'h0;
            end
            c.idle = c.ones == `IDLE_ONES;
         end
         c.rxo.valid = c.rrd != c.rcm;
         {c.rxo.status, c.rxo.data} = c.rxm[c.rrd[5:0]];
         c.trdy = (c.twr - c.trd) != `FIFO_DEPTH;
         n.ch[i] = c;
      end
      if (brise) begin
         case (m)
            M_QUAD_TS: n.mark_n = ~hv[1];
            M_QUAD_CC: n.mark_n = ~r.lv[`PIN_FS];
            default: n.mark_n = ~|hv;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         r <= '0;
         r.mark_n <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            r.ch[i].st <= T_IDLE;
            r.ch[i].tsh <= `FLAG_BYTE;
            r.ch[i].trdy <= 1'b1;
         end
      end else begin
         r <= n;
      end
   end

   assign SERIAL_TX_LANE_O = r.lo;
   assign SERIAL_TX_LANE_OE_O = r.loe;
   assign SLOT_MARKER_OUT_N_O = r.mark_n;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         TX_READY_O[i] = r.ch[i].trdy;
         RX_WORD_O[i] = r.ch[i].rxo;
         LINE_IDLE_O[i] = r.ch[i].idle;
      end
   end
endmodule // quad_hdlc_channel_access

// [design/quad_hdlc_map.svh]
// Purpose: numeric constants of the four-channel hdlc framer
// Assumes: included by the design file only
// Notes: definitions only
`ifndef QUAD_HDLC_MAP_SVH
`define QUAD_HDLC_MAP_SVH
`define FLAG_BYTE 8'h7E
`define ONES_BYTE 8'hFF
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_GOOD 16'hF0B8
`define SAPI_GROUP 6'h3F
`define SAPI_SIG 6'h00
`define SAPI_PKT 6'h10
`define STUFF_ONES 4'h5
`define FLAG_ONES 4'h6
`define ABORT_ONES 4'h7
`define IDLE_ONES 4'hF
`define MIN_BYTES 6'h03
`define BYTE_CAP 6'h3F
`define BLK_SIZE 6'h20
`define FIFO_DEPTH 7'h40
`define DATA_LIM 7'h3F
`define DLY_FULL 3'h7
`define HOLD_FULL 2'h2
`define WRAP_256 9'h0FF
`define WRAP_512 9'h1FF
`define BUS_D_PAIR 4'hC
`define LEN_1 9'h001
`define LEN_2 9'h002
`define LEN_7 9'h007
`define LEN_8 9'h008
`define ST_CRC_OK 0
`define ST_ABORT 1
`define ST_OVF 2
`define CMP_PKT 0
`define CMP_SIG 1
`define CMP_GROUP 2
`define PIN_CLK 4
`define PIN_FS 5
`endif

// [design/quad_hdlc_pkg.sv]
// Purpose: types shared by the four-channel hdlc framer
// Assumes: quad_hdlc_map.svh holds the numbers
// Notes: fifo depth of 64 entries is fixed by the channel state layout
package quad_hdlc_pkg;
   typedef enum logic [1:0] {
      M_SINGLE_TS = 2'h0,
      M_QUAD_CC = 2'h1,
      M_SUB_BUS = 2'h2,
      M_QUAD_TS = 2'h3
   } link_mode_e;
   typedef enum logic [6:0] {
      T_IDLE = 7'h01,
      T_OPEN = 7'h02,
      T_DATA = 7'h04,
      T_CRC1 = 7'h08,
      T_CRC2 = 7'h10,
      T_CLOSE = 7'h20,
      T_ABORT = 7'h40
   } tx_st_e;
   typedef struct packed {
      logic [7:0] slot_pos;
      logic [1:0] slot_len;
      logic [2:0] addr_cmp;
      logic ones_fill;
   } chan_cfg_s;
   typedef struct packed {
      logic wr;
      logic last;
      logic [7:0] data;
      logic abort;
   } tx_host_s;
   typedef struct packed {
      logic valid;
      logic status;
      logic [7:0] data;
   } rx_word_s;
   typedef struct packed {
      logic [3:0] ones;
      logic infr;
      logic [6:0] dly;
      logic [2:0] dn;
      logic [7:0] sh;
      logic [2:0] nb;
      logic [5:0] nby;
      logic [15:0] crc;
      logic [7:0] h0;
      logic [7:0] h1;
      logic [1:0] hn;
      logic rej;
      logic ovf;
      logic [63:0][8:0] rxm;
      logic [6:0] rwr;
      logic [6:0] rrd;
      logic [6:0] rcm;
      logic [5:0] rblk;
      rx_word_s rxo;
      logic idle;
      tx_st_e st;
      logic [7:0] tsh;
      logic [2:0] tn;
      logic [3:0] tones;
      logic [15:0] tcrc;
      logic tlast;
      logic tabt;
      logic [63:0][8:0] txm;
      logic [6:0] twr;
      logic [6:0] trd;
      logic [6:0] tcm;
      logic [5:0] tblk;
      logic trdy;
      logic act;
   } chan_s;
   typedef struct packed {
      logic [5:0] s0;
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] lv;
      logic ph;
      logic fsp;
      logic [8:0] bc;
      logic [3:0] lo;
      logic [3:0] loe;
      logic mark_n;
      chan_s [3:0] ch;
   } state_s;
endpackage

// [testbench/highway_peer.sv]
// Purpose: highway peer giving bit clock, frame sync and looped receive data
// Assumes: single-rate bit clock, 256-bit highway frame
// Notes: each receive lane replays its transmit wire one highway frame later
module highway_peer (
   input wire logic [3:0] tx_i,
   input wire logic [3:0] tx_oe_i,
   input wire logic od_i,
   input wire logic [3:0] strobe_bits_i,
   output logic bit_clk_o,
   output logic fs_o,
   output logic [3:0] rx_o,
   output logic [8:0] bit_idx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [255:0] mem [4];
   logic [3:0] last;
   logic line;
   initial begin
      for (int i = 0; i < 4; i++) mem[i] = '1;
      last = 4'hF;
      bit_clk_o = 1'b0;
      fs_o = 1'b0;
      rx_o = 4'hF;
      bit_idx_o = 9'h0FF;
      #7;
      forever begin
         bit_clk_o = 1'b1;
         for (int i = 0; i < 4; i++) begin
            // released wire: pulled up when open-drain, else it toggles every bit
            line = tx_oe_i[i] ? tx_i[i] : (od_i | ~last[i]);
            last[i] = line;
            mem[i][bit_idx_o[7:0]] = line;
         end
         bit_idx_o = {1'b0, bit_idx_o[7:0] + 8'h01};
         for (int i = 0; i < 4; i++) rx_o[i] = mem[i][bit_idx_o[7:0]];
         #100;
         bit_clk_o = 1'b0;
         fs_o = bit_idx_o == 9'h0FF || bit_idx_o < {5'h00, strobe_bits_i} - 9'h001;
         #100;
      end
   end
endmodule // highway_peer

// [testbench/quad_hdlc_channel_access_assertions.sv]
// Purpose: port assertions for the four-channel hdlc framer
// Assumes: link configuration changes only while reset is low
// Notes: bound from the testbench top file
module quad_hdlc_channel_access_assertions (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic SERIAL_BIT_CLOCK_I,
   input wire logic FRAME_SYNC_STROBE_I,
   input wire logic LINK_MODE_HI_I,
   input wire logic LINK_MODE_LO_I,
   input wire logic OPEN_DRAIN_I,
   input wire logic [3:0] RX_READ_I,
   input wire logic [3:0] SERIAL_TX_LANE_O,
   input wire logic [3:0] SERIAL_TX_LANE_OE_O,
   input wire logic SLOT_MARKER_OUT_N_O,
   input wire logic [3:0] TX_READY_O,
   input wire quad_hdlc_pkg::rx_word_s [3:0] RX_WORD_O,
   input wire logic [3:0] LINE_IDLE_O
);
   import quad_hdlc_pkg::*;
   logic [1:0] mode;
   logic clk_q;
   logic [3:0] age;
   assign mode = {LINK_MODE_HI_I, LINK_MODE_LO_I};
   // core cycles since the bit clock pin was first seen high
   always_ff @(posedge CORE_CLK_I) begin
      clk_q <= SERIAL_BIT_CLOCK_I;
      if (SERIAL_BIT_CLOCK_I && !clk_q) begin
         age <= 4'h0;
      end else if (age != 4'hF) begin
         age <= age + 4'h1;
      end
   end
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   property p_reset_quiet;
      $rose(RESET_N_I) |-> SERIAL_TX_LANE_OE_O == 4'h0 && SLOT_MARKER_OUT_N_O
         && TX_READY_O == 4'hF && LINE_IDLE_O == 4'h0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("reset outputs");
   property p_launch;
      $changed({SERIAL_TX_LANE_O, SERIAL_TX_LANE_OE_O, SLOT_MARKER_OUT_N_O})
         |-> age inside {[4'h2:4'h7]};
   endproperty
   a_launch: assert property (p_launch) else $error("lane change off rise");
   property p_quad_marker;
      mode == 2'h3 && !OPEN_DRAIN_I |-> SLOT_MARKER_OUT_N_O == !SERIAL_TX_LANE_OE_O[1];
   endproperty
   a_quad_marker: assert property (p_quad_marker) else $error("quad marker");
   property p_single_marker;
      mode == 2'h0 && !OPEN_DRAIN_I |-> SLOT_MARKER_OUT_N_O == !SERIAL_TX_LANE_OE_O[0];
   endproperty
   a_single_marker: assert property (p_single_marker) else $error("single marker");
   property p_shared_lane;
      !LINK_MODE_LO_I |-> SERIAL_TX_LANE_OE_O[3:1] == 3'h0;
   endproperty
   a_shared_lane: assert property (p_shared_lane) else $error("lane 1-3 driven");
   property p_strobe_marker;
      mode == 2'h1 && $changed(SLOT_MARKER_OUT_N_O)
         |-> SLOT_MARKER_OUT_N_O == !$past(FRAME_SYNC_STROBE_I, 3);
   endproperty
   a_strobe_marker: assert property (p_strobe_marker) else $error("strobe marker");
   property p_open_drain;
      (OPEN_DRAIN_I || mode == 2'h2) |-> (SERIAL_TX_LANE_O & SERIAL_TX_LANE_OE_O) == 4'h0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("drove a one");
   property p_rx_hold;
      $fell(RX_WORD_O[0].valid) |-> $past(RX_READ_I[0]) || $past(RX_READ_I[0], 2)
         || $past(RX_READ_I[0], 3);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx word lost");
   c_quad: cover property (mode == 2'h3 && !SLOT_MARKER_OUT_N_O);
   c_status: cover property (RX_WORD_O[3].valid && RX_WORD_O[3].status);
   c_idle: cover property (LINE_IDLE_O[1]);
endmodule // quad_hdlc_channel_access_assertions

// [testbench/tb_quad_hdlc_channel_access.sv]
// Purpose: self-checking bench for the four-channel hdlc framer
// Assumes: highway_peer loops each transmit lane back one frame later
// Notes: link configuration is changed only while reset is held
module tb_quad_hdlc_channel_access;
   timeunit 1ns;
   timeprecision 1ps;
   import quad_hdlc_pkg::*;
   logic clk, rst_n, bclk, fs, m_hi, m_lo, od, grp, marker_n;
   logic [3:0] rx, rd, tx, oe, rdy, idle, sb;
   logic [8:0] idx;
   chan_cfg_s [3:0] cfg;
   tx_host_s [3:0] host;
   rx_word_s [3:0] rxw;
   int miscompares;
   int checked;
   quad_hdlc_channel_access i_quad_hdlc_channel_access (
      .CORE_CLK_I(clk), .RESET_N_I(rst_n), .SERIAL_BIT_CLOCK_I(bclk),
      .FRAME_SYNC_STROBE_I(fs), .SERIAL_RX_LANE_I(rx), .LINK_MODE_HI_I(m_hi),
      .LINK_MODE_LO_I(m_lo), .DOUBLE_RATE_I(1'b0), .OPEN_DRAIN_I(od), .FRAME_512_I(1'b0),
      .BUS_CHANNEL_GROUP_SEL_I(grp), .CHAN_CFG_I(cfg), .TX_HOST_I(host), .RX_READ_I(rd),
      .SERIAL_TX_LANE_O(tx), .SERIAL_TX_LANE_OE_O(oe), .SLOT_MARKER_OUT_N_O(marker_n),
      .TX_READY_O(rdy), .RX_WORD_O(rxw), .LINE_IDLE_O(idle));
   highway_peer i_highway_peer (.tx_i(tx), .tx_oe_i(oe), .od_i(od | (m_hi & ~m_lo)),
      .strobe_bits_i(sb), .bit_clk_o(bclk), .fs_o(fs), .rx_o(rx), .bit_idx_o(idx));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // waits into highway bit n, after its launch has landed
   task automatic at_bit(input logic [8:0] n);
      int k;
      k = 0;
      while (idx === n) @(negedge clk);
      while (idx !== n && k < 3000) begin
         @(negedge clk);
         k++;
      end
      if (idx !== n) miscompares++;
      repeat (6) @(negedge clk);
   endtask
   task automatic start(input logic [1:0] m, input logic g, input logic [3:0] s,
         input chan_cfg_s [3:0] c);
      @(negedge clk);
      rst_n = 1'b0;
      {m_hi, m_lo} = m;
      grp = g;
      sb = s;
      cfg = c;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      at_bit(9'h0F0);
      at_bit(9'h002);
   endtask
   task automatic send(input int ch, input logic [7:0] b [$]);
      foreach (b[k]) begin
         while (rdy[ch] !== 1'b1) @(negedge clk);
         host[ch].wr = 1'b1;
         host[ch].data = b[k];
         host[ch].last = (k == b.size() - 1);
         @(negedge clk);
      end
      host[ch].wr = 1'b0;
      host[ch].last = 1'b0;
   endtask
   task automatic expect_rx(input int ch, input logic [7:0] b [$], input logic [7:0] st);
      int k;
      for (int n = 0; n <= b.size(); n++) begin
         k = 0;
         while (rxw[ch].valid !== 1'b1 && k < 30000) begin
            @(negedge clk);
            k++;
         end
         if (rxw[ch].valid !== 1'b1) miscompares++;
         check("rx status flag", rxw[ch].status, n == b.size());
         check("rx byte", rxw[ch].data, (n == b.size()) ? st : b[n]);
         rd[ch] = 1'b1;
         @(negedge clk);
         rd[ch] = 1'b0;
         repeat (2) @(negedge clk);
      end
   endtask
   initial begin
      chan_cfg_s [3:0] c;
      logic [8:0] s;
      logic [8:0] lens [4] = '{9'h001, 9'h002, 9'h007, 9'h008};
      logic [8:0] pts [4] = '{9'h018, 9'h099, 9'h0D9, 9'h0FA};
      miscompares = 0;
      checked = 0;
      rst_n = 1'b0;
      {m_hi, m_lo, od, grp} = 4'h0;
      sb = 4'h1;
      rd = 4'h0;
      host = '0;
      cfg = '0;
      // framing: 8-bit slots, lane 1 fills with ones, lanes 2 and 3 want sapi 16
      c[0] = '{8'h04, 2'h3, 3'h0, 1'b0};
      c[1] = '{8'h08, 2'h3, 3'h0, 1'b1};
      c[2] = '{8'h0C, 2'h3, 3'h1, 1'b0};
      c[3] = '{8'h10, 2'h3, 3'h1, 1'b0};
      start(2'h3, 1'b0, 4'h1, c);
      send(1, '{8'h40, 8'h01, 8'h02, 8'h03});
      send(0, '{8'hFC, 8'hFF, 8'h7E, 8'h3F, 8'hA5});
      send(2, '{8'h00, 8'h22, 8'h33});
      send(3, '{8'h40, 8'h5A, 8'hC3});
      repeat (3000) @(negedge clk);
      host[1].abort = 1'b1;
      @(negedge clk);
      host[1].abort = 1'b0;
      expect_rx(0, '{8'hFC, 8'hFF, 8'h7E, 8'h3F, 8'hA5}, 8'h01);
      expect_rx(3, '{8'h40, 8'h5A, 8'hC3}, 8'h01);
      check("aborted frame", rxw[1].valid, 1'b0);
      check("sapi reject", rxw[2].valid, 1'b0);
      check("idle ones", idle[1], 1'b1);
      check("flag fill", idle[0], 1'b0);
      // slot geometry: lengths 1, 2, 7, 8 at bits 10, 20, 40, 240
      c[0] = '{8'h05, 2'h0, 3'h0, 1'b0};
      c[1] = '{8'h0A, 2'h1, 3'h0, 1'b0};
      c[2] = '{8'h14, 2'h2, 3'h0, 1'b0};
      c[3] = '{8'h78, 2'h3, 3'h0, 1'b0};
      start(2'h3, 1'b0, 4'h1, c);
      for (int i = 0; i < 4; i++) begin
         s = {c[i].slot_pos, 1'b0};
         at_bit(s - 9'h001);
         check("oe before slot", oe[i], 1'b0);
         at_bit(s + lens[c[i].slot_len] - 9'h001);
         check("oe last slot bit", oe[i], 1'b1);
         at_bit(s + lens[c[i].slot_len]);
         check("oe after slot", oe[i], 1'b0);
      end
      start(2'h0, 1'b0, 4'h1, c);
      at_bit(9'h015);
      check("single lane 0", oe[0], 1'b1);
      check("single lane 1", oe[1], 1'b0);
      check("single marker", marker_n, 1'b0);
      // subscriber bus, upper channel group: d bits at 32k+24 and 32k+25
      start(2'h2, 1'b1, 4'h1, c);
      for (int i = 0; i < 4; i++) begin
         at_bit(pts[i]);
         check("bus marker", marker_n, i == 0 || i == 3);
      end
      start(2'h1, 1'b0, 4'h8, c);
      at_bit(9'h003);
      check("strobe marker", marker_n, 1'b0);
      check("strobe lanes", oe, 4'hF);
      at_bit(9'h00C);
      check("strobe end marker", marker_n, 1'b1);
      check("strobe end lanes", oe, 4'h0);
      end_of_test();
   end
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
endmodule // tb_quad_hdlc_channel_access
bind quad_hdlc_channel_access quad_hdlc_channel_access_assertions
   i_quad_hdlc_channel_access_assertions (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I),
   .SERIAL_BIT_CLOCK_I(SERIAL_BIT_CLOCK_I), .FRAME_SYNC_STROBE_I(FRAME_SYNC_STROBE_I),
   .LINK_MODE_HI_I(LINK_MODE_HI_I), .LINK_MODE_LO_I(LINK_MODE_LO_I),
   .OPEN_DRAIN_I(OPEN_DRAIN_I), .RX_READ_I(RX_READ_I), .SERIAL_TX_LANE_O(SERIAL_TX_LANE_O),
   .SERIAL_TX_LANE_OE_O(SERIAL_TX_LANE_OE_O), .SLOT_MARKER_OUT_N_O(SLOT_MARKER_OUT_N_O),
   .TX_READY_O(TX_READY_O), .RX_WORD_O(RX_WORD_O), .LINE_IDLE_O(LINE_IDLE_O));
